// File: rtl/afzt_pkg.sv
// package: constants and carrier types for the auto fan zone threshold block
package afzt_pkg;

    // ----------
    // geometry
    // ----------
    localparam int NUM_ZONES = 3;
    localparam int NUM_OUTS = 3;

    // ----------
    // register offsets
    // ----------
    localparam logic [7:0] ADDR_OUT1_FLOOR_DUTY = 8'h64;
    localparam logic [7:0] ADDR_OUT2_FLOOR_DUTY = 8'h65;
    localparam logic [7:0] ADDR_OUT3_FLOOR_DUTY = 8'h66;
    localparam logic [7:0] ADDR_ZONE1_TURN_ON_TEMP = 8'h67;
    localparam logic [7:0] ADDR_ZONE2_TURN_ON_TEMP = 8'h68;
    localparam logic [7:0] ADDR_ZONE3_TURN_ON_TEMP = 8'h69;
    localparam logic [7:0] ADDR_ZONE1_FULL_SPEED_TEMP = 8'h6a;
    localparam logic [7:0] ADDR_ZONE2_FULL_SPEED_TEMP = 8'h6b;
    localparam logic [7:0] ADDR_ZONE3_FULL_SPEED_TEMP = 8'h6c;
    localparam logic [7:0] ADDR_ZONE12_TURN_OFF_MARGIN = 8'h6d;
    localparam logic [7:0] ADDR_ZONE3_TURN_OFF_MARGIN = 8'h6e;

    // ----------
    // reset values and field positions
    // ----------
    localparam logic [7:0] RST_FLOOR_DUTY = 8'h80;
    localparam logic [7:0] RST_TURN_ON_TEMP = 8'h5a;
    localparam logic [7:0] RST_FULL_SPEED_TEMP = 8'h64;
    localparam logic [7:0] RST_ZONE12_MARGIN = 8'h44;
    localparam logic [3:0] RST_ZONE3_MARGIN = 4'h4;
    localparam int MARGIN_HI_LSB = 4;
    localparam int MARGIN_LO_LSB = 0;
    localparam logic [7:0] FULL_SPEED_DISABLE = 8'h80;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [1:0] ZONE_NONE = 2'h3;

    // 65536 / range in degrees, rounded; indexed by the 4-bit range code
    localparam logic [15:0] RANGE_RECIP [16] = '{
        16'h8000, 16'h6666, 16'h4ccd, 16'h4000,
        16'h3333, 16'h2666, 16'h2000, 16'h199a,
        16'h1333, 16'h1000, 16'h0ccd, 16'h099a,
        16'h0800, 16'h0666, 16'h04cd, 16'h0333
    };

    // ----------
    // carrier types
    // ----------
    typedef struct packed {
        logic valid;
        logic [7:0] temp;
    } afzt_temp_t;

    typedef struct packed {
        logic fan_on;
        logic over_full;
        logic [7:0] ramp_frac;
    } afzt_zone_t;

    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } afzt_reg_req_t;

endpackage

// File: rtl/afzt_zone_eval.sv
// module: per-zone threshold, hysteresis and ramp position evaluation
`timescale 1ns/1ps
`default_nettype none

module afzt_zone_eval (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // sample and thresholds
    input wire afzt_pkg::afzt_temp_t i_sample,
    input wire logic [7:0] i_turn_on_temp,
    input wire logic [7:0] i_full_speed_temp,
    input wire logic [3:0] i_margin,
    input wire logic [3:0] i_range,
    // zone state
    output afzt_pkg::afzt_zone_t o_zone
);

    afzt_pkg::afzt_zone_t state_r;
    afzt_pkg::afzt_zone_t state_nxt;
    logic signed [9:0] temp_s;
    logic signed [9:0] low_s;
    logic signed [9:0] abs_s;
    logic signed [9:0] off_s;
    logic signed [9:0] delta_s;
    logic [23:0] prod;

    always_comb begin
        state_nxt = state_r;
        temp_s = {{2{i_sample.temp[7]}}, i_sample.temp};
        low_s = {{2{i_turn_on_temp[7]}}, i_turn_on_temp};
        abs_s = {{2{i_full_speed_temp[7]}}, i_full_speed_temp};
        off_s = low_s - $signed({6'h00, i_margin});
        delta_s = temp_s - low_s;
        prod = 24'h000000;
        if (delta_s > 10'sd0) begin
            prod = 24'(delta_s[7:0] * afzt_pkg::RANGE_RECIP[i_range]);
        end
        // decisions only move when a fresh reading arrives
        if (i_sample.valid) begin
            if (temp_s >= low_s) begin
                state_nxt.fan_on = 1'b1;
            end else if (temp_s < off_s) begin
                state_nxt.fan_on = 1'b0;
            end
            state_nxt.over_full = (i_full_speed_temp != afzt_pkg::FULL_SPEED_DISABLE)
                && (temp_s > abs_s);
            state_nxt.ramp_frac = (prod[23:8] >= 16'h00ff) ? afzt_pkg::DUTY_FULL
                : prod[15:8];
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_zone = state_r;

endmodule // afzt_zone_eval

`default_nettype wire

// File: rtl/afzt_out_duty.sv
// module: per-output duty selection from zone state, floor and overrides
`timescale 1ns/1ps
`default_nettype none

module afzt_out_duty (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // controls
    input wire afzt_pkg::afzt_zone_t i_zone,
    input wire logic i_zone_valid,
    input wire logic [7:0] i_floor_duty,
    input wire logic i_below_limit_select,
    input wire logic i_auto,
    input wire logic i_disabled,
    input wire logic [7:0] i_manual_duty,
    input wire logic i_force_full,
    // duty
    output logic [7:0] o_duty
);

    logic [7:0] duty_r;
    logic [7:0] duty_nxt;
    logic [7:0] span;
    logic [15:0] ramp;
    logic [8:0] sum;

    always_comb begin
        // floor value is a fraction of 255, so ffh already means 100 percent
        span = afzt_pkg::DUTY_FULL - i_floor_duty;
        ramp = {8'h00, span} * {8'h00, i_zone.ramp_frac};
        sum = {1'b0, i_floor_duty} + {1'b0, ramp[15:8]};
        duty_nxt = afzt_pkg::DUTY_OFF;
        if (i_disabled) begin
            duty_nxt = afzt_pkg::DUTY_OFF;
        end else if (i_force_full) begin
            duty_nxt = afzt_pkg::DUTY_FULL;
        end else if (!i_auto) begin
            duty_nxt = i_manual_duty;
        end else if (!i_zone_valid) begin
            duty_nxt = afzt_pkg::DUTY_OFF;
        end else if (i_zone.fan_on) begin
            if (i_zone.ramp_frac == afzt_pkg::DUTY_FULL || sum[8]) begin
                duty_nxt = afzt_pkg::DUTY_FULL;
            end else begin
                duty_nxt = sum[7:0];
            end
        end else begin
            duty_nxt = i_below_limit_select ? i_floor_duty : afzt_pkg::DUTY_OFF;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            duty_r <= afzt_pkg::DUTY_OFF;
        end else begin
            duty_r <= duty_nxt;
        end
    end

    assign o_duty = duty_r;

endmodule // afzt_out_duty

`default_nettype wire

// File: rtl/afzt_top.sv
// module: threshold register file and automatic fan zone control top
//
// Function
// - lock bit makes all threshold registers read-only
// - at turn-on temperature drive floor duty
// - floor duty is value over 255
// - temperature equal turn-on limit starts fan
// - above limit duty rises per zone range
// - limits are signed two's-complement whole degrees
// - over full-speed limit forces enabled outputs full while any output is automatic
// - full-speed limit 80h disables that zone's override
// - override hits manual outputs and unassigned zones
// - fan stays at floor until below margin
// - margin field is whole degrees per step
// - margin nibbles: 6Dh zones 1,2; 6Eh zone 3
// - linear ramp floor to full across range
// - below-limit select picks off or floor
`timescale 1ns/1ps
`default_nettype none

module afzt_top #(
    parameter int NUM_ZONES = afzt_pkg::NUM_ZONES,
    parameter int NUM_OUTS = afzt_pkg::NUM_OUTS
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // register access from the serial interface engine
    input wire afzt_pkg::afzt_reg_req_t i_reg_req,
    input wire logic i_lock,
    output logic [7:0] o_reg_rdata,
    // temperature readings
    input wire afzt_pkg::afzt_temp_t [NUM_ZONES-1:0] i_temp,
    input wire logic [NUM_ZONES-1:0][3:0] i_zone_range,
    // output configuration
    input wire logic [NUM_OUTS-1:0][1:0] i_out_zone,
    input wire logic [NUM_OUTS-1:0] i_out_auto,
    input wire logic [NUM_OUTS-1:0] i_out_disabled,
    input wire logic [NUM_OUTS-1:0][7:0] i_out_manual_duty,
    input wire logic [NUM_OUTS-1:0] i_out_below_limit_select,
    // duty and status
    output logic [NUM_OUTS-1:0][7:0] o_out_duty,
    output logic [NUM_ZONES-1:0] o_zone_fan_on,
    output logic o_full_speed_override
);

    // ----------
    // state
    // ----------
    typedef struct packed {
        logic [2:0][7:0] floor_duty;
        logic [2:0][7:0] turn_on_temp;
        logic [2:0][7:0] full_speed_temp;
        logic [7:0] zone12_margin;
        logic [3:0] zone3_margin;
        logic [7:0] rdata;
        logic override;
    } afzt_state_t;

    afzt_state_t state_r;
    afzt_state_t state_nxt;

    afzt_pkg::afzt_zone_t [NUM_ZONES-1:0] zone_st;
    logic [NUM_ZONES-1:0][3:0] zone_margin;
    logic any_over;
    logic any_auto;

    // ----------
    // margin nibble split
    // ----------
    always_comb begin
        zone_margin = '0;
        zone_margin[0] = state_r.zone12_margin[afzt_pkg::MARGIN_HI_LSB +: 4];
        zone_margin[1] = state_r.zone12_margin[afzt_pkg::MARGIN_LO_LSB +: 4];
        zone_margin[2] = state_r.zone3_margin;
    end

    // ----------
    // register write and read
    // ----------
    always_comb begin
        state_nxt = state_r;

        // a locked block simply drops the write; the host sees nothing
        if (i_reg_req.wr_en && !i_lock) begin
            unique case (i_reg_req.addr)
                afzt_pkg::ADDR_OUT1_FLOOR_DUTY: begin
                    state_nxt.floor_duty[0] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_OUT2_FLOOR_DUTY: begin
                    state_nxt.floor_duty[1] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_OUT3_FLOOR_DUTY: begin
                    state_nxt.floor_duty[2] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_ZONE1_TURN_ON_TEMP: begin
                    state_nxt.turn_on_temp[0] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_ZONE2_TURN_ON_TEMP: begin
                    state_nxt.turn_on_temp[1] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_ZONE3_TURN_ON_TEMP: begin
                    state_nxt.turn_on_temp[2] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_ZONE1_FULL_SPEED_TEMP: begin
                    state_nxt.full_speed_temp[0] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_ZONE2_FULL_SPEED_TEMP: begin
                    state_nxt.full_speed_temp[1] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_ZONE3_FULL_SPEED_TEMP: begin
                    state_nxt.full_speed_temp[2] = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_ZONE12_TURN_OFF_MARGIN: begin
                    state_nxt.zone12_margin = i_reg_req.wdata;
                end
                afzt_pkg::ADDR_ZONE3_TURN_OFF_MARGIN: begin
                    // low nibble is reserved and not stored
                    state_nxt.zone3_margin =
                        i_reg_req.wdata[afzt_pkg::MARGIN_HI_LSB +: 4];
                end
                default: begin
                end
            endcase
        end

        // read data follows the address one clock later
        unique case (i_reg_req.addr)
            afzt_pkg::ADDR_OUT1_FLOOR_DUTY: begin
                state_nxt.rdata = state_r.floor_duty[0];
            end
            afzt_pkg::ADDR_OUT2_FLOOR_DUTY: begin
                state_nxt.rdata = state_r.floor_duty[1];
            end
            afzt_pkg::ADDR_OUT3_FLOOR_DUTY: begin
                state_nxt.rdata = state_r.floor_duty[2];
            end
            afzt_pkg::ADDR_ZONE1_TURN_ON_TEMP: begin
                state_nxt.rdata = state_r.turn_on_temp[0];
            end
            afzt_pkg::ADDR_ZONE2_TURN_ON_TEMP: begin
                state_nxt.rdata = state_r.turn_on_temp[1];
            end
            afzt_pkg::ADDR_ZONE3_TURN_ON_TEMP: begin
                state_nxt.rdata = state_r.turn_on_temp[2];
            end
            afzt_pkg::ADDR_ZONE1_FULL_SPEED_TEMP: begin
                state_nxt.rdata = state_r.full_speed_temp[0];
            end
            afzt_pkg::ADDR_ZONE2_FULL_SPEED_TEMP: begin
                state_nxt.rdata = state_r.full_speed_temp[1];
            end
            afzt_pkg::ADDR_ZONE3_FULL_SPEED_TEMP: begin
                state_nxt.rdata = state_r.full_speed_temp[2];
            end
            afzt_pkg::ADDR_ZONE12_TURN_OFF_MARGIN: begin
                state_nxt.rdata = state_r.zone12_margin;
            end
            afzt_pkg::ADDR_ZONE3_TURN_OFF_MARGIN: begin
                state_nxt.rdata = {state_r.zone3_margin, 4'h0};
            end
            default: begin
                state_nxt.rdata = afzt_pkg::READ_UNMAPPED;
            end
        endcase

        // ----------
        // safety override
        // ----------
        // any zone counts, assigned to a fan or not, as long as one
        // output is in automatic mode
        state_nxt.override = any_over && any_auto;
    end

    always_comb begin
        any_over = 1'b0;
        for (int z = 0; z < NUM_ZONES; z++) begin
            any_over = any_over | zone_st[z].over_full;
        end
        any_auto = |i_out_auto;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r.floor_duty <= {3{afzt_pkg::RST_FLOOR_DUTY}};
            state_r.turn_on_temp <= {3{afzt_pkg::RST_TURN_ON_TEMP}};
            state_r.full_speed_temp <= {3{afzt_pkg::RST_FULL_SPEED_TEMP}};
            state_r.zone12_margin <= afzt_pkg::RST_ZONE12_MARGIN;
            state_r.zone3_margin <= afzt_pkg::RST_ZONE3_MARGIN;
            state_r.rdata <= afzt_pkg::READ_UNMAPPED;
            state_r.override <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------
    // zone evaluation
    // ----------
    genvar gz;
    generate
        for (gz = 0; gz < NUM_ZONES; gz++) begin : g_zone
            afzt_zone_eval u_zone (
                .i_clock(i_clock),
                .i_sys_rst(i_sys_rst),
                .i_sample(i_temp[gz]),
                .i_turn_on_temp(state_r.turn_on_temp[gz]),
                .i_full_speed_temp(state_r.full_speed_temp[gz]),
                .i_margin(zone_margin[gz]),
                .i_range(i_zone_range[gz]),
                .o_zone(zone_st[gz])
            );
            assign o_zone_fan_on[gz] = zone_st[gz].fan_on;
        end
    endgenerate

    // ----------
    // output duty
    // ----------
    // an output assigned to no zone idles at zero in automatic mode,
    // but still follows the safety override
    genvar go;
    generate
        for (go = 0; go < NUM_OUTS; go++) begin : g_out
            afzt_pkg::afzt_zone_t sel_zone;
            logic sel_valid;

            always_comb begin
                sel_zone = '0;
                sel_valid = 1'b0;
                for (int z = 0; z < NUM_ZONES; z++) begin
                    if (i_out_zone[go] == 2'(z)) begin
                        sel_zone = zone_st[z];
                        sel_valid = 1'b1;
                    end
                end
            end

            afzt_out_duty u_duty (
                .i_clock(i_clock),
                .i_sys_rst(i_sys_rst),
                .i_zone(sel_zone),
                .i_zone_valid(sel_valid),
                .i_floor_duty(state_r.floor_duty[go]),
                .i_below_limit_select(i_out_below_limit_select[go]),
                .i_auto(i_out_auto[go]),
                .i_disabled(i_out_disabled[go]),
                .i_manual_duty(i_out_manual_duty[go]),
                .i_force_full(state_r.override),
                .o_duty(o_out_duty[go])
            );
        end
    endgenerate

    // ----------
    // outputs
    // ----------
    assign o_reg_rdata = state_r.rdata;
    assign o_full_speed_override = state_r.override;

endmodule // afzt_top

`default_nettype wire

// File: dv/afzt_host_model.sv
// partner model: host that programs the threshold registers of the block
`timescale 1ns/1ps
`default_nettype none

module afzt_host_model (
    // clock
    input wire logic i_clock,
    // register request toward the block
    output afzt_pkg::afzt_reg_req_t o_reg_req,
    output logic o_lock
);
    initial begin
        o_reg_req = '0;
        o_lock = 1'b0;
    end

    // idle data is inverted so a stale byte never looks like the written one
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clock);
        o_reg_req <= '{1'b1, addr, data};
        @(posedge i_clock);
        o_reg_req <= '{1'b0, addr, ~data};
    endtask

    task automatic point(input logic [7:0] addr);
        @(posedge i_clock);
        o_reg_req.addr <= addr;
    endtask

    task automatic set_lock(input logic v);
        @(posedge i_clock);
        o_lock <= v;
    endtask

    // a zone without fans gets the top limit 127, which no reading can exceed, so it never trips
    task automatic park_zone(input int zone);
        wr(8'h6a + 8'(zone), 8'h7f);
    endtask
endmodule // afzt_host_model
`default_nettype wire

// File: dv/afzt_checker.sv
// checker: port-level properties of the fan zone threshold block
`timescale 1ns/1ps
`default_nettype none

module afzt_checker #(
    parameter int NUM_ZONES = 3,
    parameter int NUM_OUTS = 3
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // register access
    input wire afzt_pkg::afzt_reg_req_t i_reg_req,
    input wire logic i_lock,
    input wire logic [7:0] o_reg_rdata,
    // readings and configuration
    input wire afzt_pkg::afzt_temp_t [NUM_ZONES-1:0] i_temp,
    input wire logic [NUM_ZONES-1:0][3:0] i_zone_range,
    input wire logic [NUM_OUTS-1:0][1:0] i_out_zone,
    input wire logic [NUM_OUTS-1:0] i_out_auto,
    input wire logic [NUM_OUTS-1:0] i_out_disabled,
    input wire logic [NUM_OUTS-1:0][7:0] i_out_manual_duty,
    input wire logic [NUM_OUTS-1:0] i_out_below_limit_select,
    // duty and status
    input wire logic [NUM_OUTS-1:0][7:0] o_out_duty,
    input wire logic [NUM_ZONES-1:0] o_zone_fan_on,
    input wire logic o_full_speed_override
);
    // ----------
    // shadow of output 1 floor, zone 1 and zone 3 settings
    // ----------
    logic [7:0] fl_r, on_r, fs3_r;
    logic [3:0] hy_r;
    logic signed [9:0] t0, lim0, off0;
    logic v0;
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fl_r <= 8'h80;
            on_r <= 8'h5a;
            fs3_r <= 8'h64;
            hy_r <= 4'h4;
        end else if (i_reg_req.wr_en && !i_lock) begin
            case (i_reg_req.addr)
                8'h64: fl_r <= i_reg_req.wdata;
                8'h67: on_r <= i_reg_req.wdata;
                8'h6c: fs3_r <= i_reg_req.wdata;
                8'h6d: hy_r <= i_reg_req.wdata[7:4];
                default: ;
            endcase
        end
    end
    assign v0 = i_temp[0].valid;
    assign t0 = 10'($signed(i_temp[0].temp));
    assign lim0 = 10'($signed(on_r));
    assign off0 = lim0 - $signed({6'h0, hy_r});

    // ----------
    // properties
    // ----------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    property p_lock_hold;
        i_lock && i_reg_req.wr_en ##1 $stable(i_reg_req.addr) |=> $stable(o_reg_rdata);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked write took effect");
    property p_turn_on;
        v0 && t0 >= lim0 |=> o_zone_fan_on[0];
    endproperty
    a_turn_on: assert property (p_turn_on) else $error("fan not on at limit");
    property p_turn_off;
        v0 && t0 < off0 |=> !o_zone_fan_on[0];
    endproperty
    a_turn_off: assert property (p_turn_off) else $error("fan on below margin");
    property p_margin_hold;
        v0 && t0 < lim0 && t0 >= off0 |=> $stable(o_zone_fan_on[0]);
    endproperty
    a_margin_hold: assert property (p_margin_hold) else $error("fan state moved");
    property p_floor;
        v0 && t0 == lim0 && i_out_auto[0] && !i_out_disabled[0] && i_out_zone[0] == 2'h0
            ##1 !o_full_speed_override [*2] |-> o_out_duty[0] == fl_r;
    endproperty
    a_floor: assert property (p_floor) else $error("duty not floor at limit");
    property p_over;
        i_temp[2].valid && fs3_r != 8'h80 && $signed(i_temp[2].temp) > $signed(fs3_r)
            && |i_out_auto ##1 |i_out_auto |=> o_full_speed_override;
    endproperty
    a_over: assert property (p_over) else $error("override missing");
    property p_full;
        o_full_speed_override && i_out_disabled[1:0] == 2'b00
            |=> o_out_duty[0] == 8'hff && o_out_duty[1] == 8'hff;
    endproperty
    a_full: assert property (p_full) else $error("output not full");
    property p_disabled;
        o_full_speed_override && i_out_disabled[2] |=> o_out_duty[2] == 8'h00;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled output driven");
    property p_abs_off;
        i_temp[2].valid && fs3_r == 8'h80 && !i_temp[0].valid && !i_temp[1].valid
            && |i_out_auto ##1 !o_full_speed_override && $stable(i_out_auto)
            |=> !o_full_speed_override;
    endproperty
    a_abs_off: assert property (p_abs_off) else $error("override from off zone");
    property p_below;
        !o_zone_fan_on[0] && i_out_auto[0] && !i_out_disabled[0] && i_out_zone[0] == 2'h0
            && !o_full_speed_override |=> o_out_duty[0]
            == ($past(i_out_below_limit_select[0]) ? $past(fl_r) : 8'h00);
    endproperty
    a_below: assert property (p_below) else $error("wrong duty below limit");
    c_override: cover property (o_full_speed_override);
    c_margin: cover property (v0 && t0 < lim0 && t0 >= off0 && o_zone_fan_on[0]);
    c_select: cover property (!o_zone_fan_on[0] && i_out_below_limit_select[0]);
endmodule // afzt_checker

bind afzt_top afzt_checker #(.NUM_ZONES(NUM_ZONES), .NUM_OUTS(NUM_OUTS)) u_checker (.*);
`default_nettype wire

// File: dv/test_auto_fan_zone_thresholds.sv
// testbench: registers, thresholds, margin and override of the fan zone block
`timescale 1ns/1ps
`default_nettype none

module test_auto_fan_zone_thresholds;
    typedef struct {
        int cyc;
        int sel;
        logic [7:0] exp;
        string what;
    } afzt_note_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    afzt_pkg::afzt_reg_req_t req;
    logic lock;
    logic [7:0] rdata;
    afzt_pkg::afzt_temp_t [2:0] temp = '0;
    logic [2:0][3:0] rng = {3{4'h6}};
    logic [2:0][1:0] ozone = {2'h1, 2'h3, 2'h0};
    logic [2:0] oauto = 3'b101;
    logic [2:0] odis = 3'b100;
    logic [2:0] osel = 3'b000;
    logic [2:0][7:0] mdut = {8'h11, 8'h3c, 8'h22};
    logic [2:0][7:0] duty;
    logic [2:0] fan_on;
    logic ovr;
    logic [3:0] marg [3] = '{4'h0, 4'h5, 4'hf};
    afzt_note_t notes[$];
    afzt_note_t n;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 32'he35beede;
    logic [7:0] fl, d;

    always #10 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    afzt_host_model u_host (.i_clock(clock), .o_reg_req(req), .o_lock(lock));
    afzt_top u_dut (
        .i_clock(clock), .i_sys_rst(rst), .i_reg_req(req), .i_lock(lock),
        .o_reg_rdata(rdata), .i_temp(temp), .i_zone_range(rng), .i_out_zone(ozone),
        .i_out_auto(oauto), .i_out_disabled(odis), .i_out_manual_duty(mdut),
        .i_out_below_limit_select(osel), .o_out_duty(duty), .o_zone_fan_on(fan_on),
        .o_full_speed_override(ovr)
    );

    function automatic logic [7:0] seen(input int sel);
        case (sel)
            0: return rdata;
            1, 2, 3: return duty[sel-1];
            4: return {5'h0, fan_on};
            default: return {7'h0, ovr};
        endcase
    endfunction

    function automatic logic [7:0] rst_val(input int a);
        if (a < 8'h64 || a > 8'h6e) return 8'h00;
        if (a < 8'h67) return 8'h80;
        if (a < 8'h6a) return 8'h5a;
        if (a < 8'h6d) return 8'h64;
        return (a == 8'h6d) ? 8'h44 : 8'h40;
    endfunction

    // dly counts edges from the edge the calling task last waited on
    task automatic note(input int dly, input int sel, input logic [7:0] exp, input string what);
        notes.push_back('{cyc + dly, sel, exp, what});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host.point(a);
        note(2, 0, exp, "register read");
    endtask

    task automatic sample(input int z, input logic [7:0] t);
        @(posedge clock);
        temp[z] <= '{1'b1, t};
        @(posedge clock);
        temp[z].valid <= 1'b0;
    endtask

    task automatic settle();
        repeat (4) @(posedge clock);
    endtask

    task automatic end_of_test();
        errors += notes.size();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(negedge clock) begin
        while (notes.size() > 0 && notes[0].cyc == cyc) begin
            n = notes.pop_front();
            check_count++;
            if (seen(n.sel) !== n.exp) begin
                errors++;
                $display("wrong value %s expected %h seen %h", n.what, n.exp, seen(n.sel));
            end
        end
    end

    always @(posedge clock) begin
        if (cyc > 4000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int a = 8'h63; a <= 8'h6f; a++) begin
            rd(8'(a), rst_val(a));
        end
        $display("done: reset values");
        for (int a = 8'h64; a <= 8'h6e; a++) begin
            d = 8'($random(seed));
            u_host.wr(8'(a), d);
            rd(8'(a), (a == 8'h6e) ? (d & 8'hf0) : d);
            u_host.set_lock(1'b1);
            u_host.wr(8'(a), ~d);
            rd(8'(a), (a == 8'h6e) ? (d & 8'hf0) : d);
            u_host.set_lock(1'b0);
        end
        $display("done: write and lock");
        u_host.wr(8'h67, 8'h30);
        u_host.wr(8'h6a, 8'h64);
        u_host.park_zone(1);
        u_host.park_zone(2);
        for (int k = 0; k <= 9; k++) begin
            fl = 8'($random(seed));
            u_host.wr(8'h64, fl);
            sample(0, 8'h30 + 8'(k));
            note(1, 4, 8'h01, "zone fan state");
            note(2, 1, (k >= 8) ? 8'hff : fl + 8'((int'(8'hff - fl) * k) / 8), "ramp");
            settle();
        end
        $display("done: ramp");
        for (int i = 0; i < 3; i++) begin
            u_host.wr(8'h6d, {marg[i], 4'h4});
            sample(0, 8'h30);
            settle();
            sample(0, 8'h30 - 8'(marg[i]));
            note(1, 4, 8'h01, "fan inside margin");
            note(2, 1, fl, "floor inside margin");
            settle();
            sample(0, 8'h2f - 8'(marg[i]));
            note(1, 4, 8'h00, "fan below margin");
            note(2, 1, 8'h00, "duty off below limit");
            settle();
            osel[0] <= 1'b1;
            note(2, 1, fl, "floor below limit");
            settle();
            osel[0] <= 1'b0;
        end
        $display("done: margin");
        u_host.wr(8'h67, 8'hce);
        sample(0, 8'h10);
        note(1, 4, 8'h01, "signed turn on");
        settle();
        sample(0, 8'hbe);
        note(1, 4, 8'h00, "signed turn off");
        settle();
        sample(0, 8'hce);
        note(1, 4, 8'h01, "turn on at limit");
        settle();
        $display("done: signed limits");
        u_host.wr(8'h6c, 8'h20);
        sample(2, 8'h21);
        note(2, 5, 8'h01, "override");
        note(3, 1, 8'hff, "auto output full");
        note(3, 2, 8'hff, "manual output full");
        note(3, 3, 8'h00, "disabled output");
        settle();
        sample(2, 8'h20);
        note(2, 5, 8'h00, "override at limit");
        note(3, 2, 8'h3c, "manual duty");
        settle();
        u_host.wr(8'h6c, 8'h80);
        sample(2, 8'h81);
        note(2, 5, 8'h00, "override switched off");
        settle();
        u_host.park_zone(2);
        sample(2, 8'h7f);
        note(2, 5, 8'h00, "parked zone");
        settle();
        $display("done: override");
        end_of_test();
    end
endmodule // test_auto_fan_zone_thresholds
`default_nettype wire
